// File: core/acl_device.sv
// Amplifier end: channel states, gain ramps, faults, load diagnostics and clip/warning output.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "acl_regs.svh"
//
// Contract
// - Mute and play ramp gain gradually.
// - Faults force high impedance with no ramp.
// - Gain chosen from four register settings.
// - Gains 12, 20, 26, 32 dB per channel.
// - Writable offset reduction enable bit.
// - Diagnostics only on high impedance channels.
// - All hiz: four phases, all channels together.
// - Some hiz: rail and ground shorts only.
// - Host mutes, then hiz, before diagnostics.
// - Ramp down completes before diagnostics start.
// - Results held in per-channel readable registers.
// - Host writes no mode during diagnostics.
// - Host tests tweeter channels one at time.
// - Host sets channel to play after entry.
// - Host selects tweeter source for results.
// - Clip source: clip, warning, both, tweeter.
// - Tweeter: line low while current over threshold.
// - Tweeter low pulse lasts one PWM period.
module acl_device
    import acl_pkg::*;
#(
    parameter int LEVEL_W   = 6,
    parameter int STEP_CYC  = `ACL_RAMP_STEP_CYC,
    parameter int PWM_CYC   = `ACL_PWM_PERIOD_CYC,
    parameter int PHASE_CYC = `ACL_DIAG_PHASE_CYC
)(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    acl_link_if.dev                     link,
    input  wire logic [4:0]             fault_in,        // Overvoltage, undervoltage, current, temp, offset.
    input  wire logic                   clip_detect,     // Full duty cycle seen on some channel.
    input  wire logic                   temperature_warning,
    input  wire logic                   over_threshold,  // Load current above tweeter threshold.
    input  wire logic [3:0]             diag_sense,      // Per-channel comparator of the current phase.
    output logic [3:0]                  ch_hiz,          // Output stage released per channel.
    output logic [3:0][LEVEL_W-1:0]     ch_gain_level,   // Ramped gain level per channel.
    output logic [7:0]                  gain_sel,        // Gain code, two bits per channel.
    output logic                        offset_reduction_en,
    output logic                        diag_active,
    output logic [1:0]                  diag_phase
);
    initial
    begin
        if (PWM_CYC < 1 || PHASE_CYC < 2 || PWM_CYC > 65535 || PHASE_CYC > 65535)
            $error("acl_device: bad PWM_CYC or PHASE_CYC");
    end

    localparam logic [15:0] PWM_LAST   = 16'(PWM_CYC - 1);
    localparam logic [15:0] PHASE_LAST = 16'(PHASE_CYC - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]         mode;      // Two-bit state per channel.
        logic [7:0]         gain;      // Two-bit gain code per channel.
        logic [7:0]         ctrl;      // Offset enable and tweeter mode.
        logic [1:0]         clip_src;  // Clip/warning source selection.
        logic [4:0]         fault;     // Sticky fault flags, cleared by read.
        acl_diag_state_type diag_st;   // Diagnostic sequencer.
        logic               full;      // Full level under way.
        logic [1:0]         phase;     // Present test phase.
        logic [15:0]        phase_cnt; // Cycles spent in the phase.
        logic [3:0]         mask;      // Channels under test.
        logic [3:0][3:0]    result;    // Per-channel phase results.
        logic [3:0]         hiz;       // Registered output release.
        logic               clip_low;  // Clip/warning line pulled low.
        logic [15:0]        stretch;   // Remaining minimum low time.
        logic               ack;       // Link answer.
        logic [7:0]         rdata;     // Link read data.
    } acl_dev_state_type;

    acl_dev_state_type q, d;
    logic [3:0]        at_zero;   // Ramp of each channel is silent.
    logic [3:0]        hiz_ready; // Channel in hiz with its ramp finished.
    logic              start_req; // Diagnostic start written this cycle.
    logic              fault_any; // Any fault seen this cycle.
    logic              tweet_hit; // Tweeter current over threshold in mode.

    assign fault_any = |fault_in;

    // ****************************************************************
    // Gain ramps, one per channel
    // ****************************************************************
    for (genvar ch = 0; ch < 4; ch++)
    begin : g_ramp
        acl_ramp #(
            .LEVEL_W  (LEVEL_W),
            .STEP_CYC (STEP_CYC)
        ) u_ramp (
            .pclk       (pclk),
            .presetn    (presetn),
            .target_up  (acl_chmode_type'(q.mode[2*ch +: 2]) == ACL_PLAY),
            .force_zero (fault_any),
            .level      (ch_gain_level[ch]),
            .at_zero    (at_zero[ch])
        );
        // A channel set to hiz is released only after its ramp reached zero.
        assign hiz_ready[ch] = (acl_chmode_type'(q.mode[2*ch +: 2]) == ACL_HIZ) && at_zero[ch];
    end

    assign tweet_hit = q.ctrl[`ACL_CTRL_TWEET_BIT] && over_threshold;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Link access first, then faults, so a fault always wins over a mode write or a fault clear.
    always_comb
    begin
        d         = q;
        d.ack     = 1'b0;
        start_req = 1'b0;

        // Skipping while ack is up avoids taking the same request twice.
        if (link.req && !q.ack)
        begin
            d.ack = 1'b1;
            if (link.wr)
            begin
                case (link.addr)
                    `ACL_REG_GAIN:     d.gain = link.wdata;
                    `ACL_REG_CTRL:
                    begin
                        d.ctrl      = link.wdata & 8'h05;
                        start_req   = link.wdata[`ACL_CTRL_START_BIT];
                    end
                    `ACL_REG_CLIP_SRC: d.clip_src = link.wdata[1:0];
                    `ACL_REG_MODE:
                    begin
                        // Mode writes during a test are dropped to protect the sequence.
                        if (q.diag_st == ACL_DIAG_IDLE)
                            d.mode = link.wdata;
                    end
                    default:           d.ack = 1'b1;
                endcase
            end
            else
            begin
                case (link.addr)
                    `ACL_REG_FAULT:
                    begin
                        d.rdata = {3'h0, q.fault};
                        d.fault = '0;
                    end
                    `ACL_REG_GAIN:      d.rdata = q.gain;
                    `ACL_REG_CTRL:      d.rdata = q.ctrl;
                    `ACL_REG_DIAG_STAT: d.rdata = {q.mask, q.phase, q.full, q.diag_st == ACL_DIAG_RUN};
                    `ACL_REG_CLIP_SRC:  d.rdata = {6'h00, q.clip_src};
                    `ACL_REG_MODE:      d.rdata = q.mode;
                    8'h10, 8'h11, 8'h12, 8'h13:
                        d.rdata = {4'h0, q.result[link.addr[1:0]]};
                    default:            d.rdata = 8'h00;
                endcase
            end
        end

        // Load diagnostic sequencer.
        case (q.diag_st)
            ACL_DIAG_IDLE:
            begin
                // A start with no channel ready in hiz is ignored.
                if (start_req && (|hiz_ready) && !fault_any)
                begin
                    d.diag_st   = ACL_DIAG_RUN;
                    d.mask      = hiz_ready;
                    d.full      = &hiz_ready;
                    d.phase     = 2'h0;
                    d.phase_cnt = '0;
                    for (int ch = 0; ch < 4; ch++)
                    begin
                        if (hiz_ready[ch])
                            d.result[ch] = 4'h0;
                    end
                end
            end
            ACL_DIAG_RUN:
            begin
                if (q.phase_cnt == PHASE_LAST)
                begin
                    d.phase_cnt = '0;
                    // All tested channels are sampled at once at the phase end.
                    for (int ch = 0; ch < 4; ch++)
                    begin
                        if (q.mask[ch])
                            d.result[ch][q.phase] = diag_sense[ch];
                    end
                    // The reduced level stops after the rail and ground phases.
                    if (q.phase == (q.full ? 2'h3 : 2'h1))
                        d.diag_st = ACL_DIAG_IDLE;
                    else
                        d.phase = q.phase + 1'b1;
                end
                else
                    d.phase_cnt = q.phase_cnt + 1'b1;
            end
            default: d.diag_st = ACL_DIAG_IDLE;
        endcase

        // Faults: sticky flag, all channels to hiz at once, test aborted.
        if (fault_any)
        begin
            d.fault   = d.fault | fault_in;
            d.mode    = `ACL_MODE_RESET;
            d.diag_st = ACL_DIAG_IDLE;
        end

        // Channels in hiz with their ramp at zero, or all of them on a fault, release the output stage.
        for (int ch = 0; ch < 4; ch++)
            d.hiz[ch] = fault_any || hiz_ready[ch];

        // Clip/warning line, with the tweeter low time stretched to a PWM period.
        case (acl_clip_src_type'(q.clip_src))
            ACL_SRC_CLIP:  d.clip_low = clip_detect;
            ACL_SRC_WARN:  d.clip_low = temperature_warning;
            ACL_SRC_BOTH:  d.clip_low = clip_detect || temperature_warning;
            ACL_SRC_TWEET:
            begin
                if (tweet_hit && !q.clip_low)
                    d.stretch = PWM_LAST;
                else if (q.stretch != '0)
                    d.stretch = q.stretch - 1'b1;
                d.clip_low = tweet_hit || (q.clip_low && q.stretch != '0);
            end
            default:       d.clip_low = 1'b0;
        endcase
    end

    // Registers the whole device state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q          <= '0;
            q.mode     <= `ACL_MODE_RESET;
            q.gain     <= `ACL_GAIN_RESET;
            q.ctrl     <= `ACL_CTRL_RESET;
            q.clip_src <= `ACL_CLIP_SRC_RESET;
            q.diag_st  <= ACL_DIAG_IDLE;
            q.hiz      <= 4'hf;
        end
        else
            q <= d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.ack            = q.ack;
    assign link.rdata          = q.rdata;
    assign link.diag_busy      = (q.diag_st == ACL_DIAG_RUN);
    assign link.clip_out       = 1'b0;
    assign link.clip_oe        = q.clip_low;
    assign ch_hiz              = q.hiz;
    assign gain_sel            = q.gain;
    assign offset_reduction_en = q.ctrl[`ACL_CTRL_OFFSET_BIT];
    assign diag_active         = (q.diag_st == ACL_DIAG_RUN);
    assign diag_phase          = q.phase;
endmodule : acl_device

// File: core/acl_host.sv
// Controller end: APB registers that issue link transfers to the amplifier.
`timescale 1ns/1ps
`include "acl_regs.svh"
module acl_host
    import acl_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    acl_link_if.host         link
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic        req;      // Link request outstanding.
        logic        wr;       // Direction of the request.
        logic [7:0]  addr;     // Device register offset.
        logic [7:0]  wdata;    // Device write data.
        logic [7:0]  rdata;    // Last read answer.
        logic [2:0]  int_stat; // Sticky events, cleared by read.
        logic [2:0]  int_mask; // Interrupt enables.
        logic        clip_prev;// Line level one cycle ago.
        logic [31:0] prdata;   // Read data held for the access phase.
    } acl_host_state_type;

    acl_host_state_type q, d;
    logic setup;  // APB setup cycle.
    logic access; // APB access cycle, always completed at once.

    assign setup  = psel && !penable;
    assign access = psel && penable;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Software writes the sequences; this block only guards what it can see.
    always_comb
    begin
        d           = q;
        d.clip_prev = link.clip_level;
        if (setup && !pwrite)
        begin
            case (paddr)
                `ACL_APB_STATUS:   d.prdata = {16'h0000, q.rdata, 5'h00, link.clip_level,
                                               link.diag_busy, q.req};
                `ACL_APB_INT_STAT: d.prdata = {29'h0, q.int_stat};
                `ACL_APB_INT_MASK: d.prdata = {29'h0, q.int_mask};
                default:           d.prdata = 32'h0000_0000;
            endcase
        end
        if (access && pwrite)
        begin
            case (paddr)
                `ACL_APB_CMD:
                begin
                    // A mode write during a test would upset it, so it is refused.
                    if (q.req || (pwdata[`ACL_CMD_WRITE_BIT] && pwdata[15:8] == `ACL_REG_MODE
                                  && link.diag_busy))
                        d.int_stat[`ACL_INT_REFUSE_BIT] = 1'b1;
                    else
                    begin
                        // Commands go out in the order written, mute before hiz.
                        d.req   = 1'b1;
                        d.wr    = pwdata[`ACL_CMD_WRITE_BIT];
                        d.addr  = pwdata[15:8];
                        d.wdata = pwdata[7:0];
                    end
                end
                `ACL_APB_INT_MASK: d.int_mask = pwdata[2:0];
                default:           d.req = q.req;
            endcase
        end
        // Only the bits shown in the read data are cleared, so an event that lands
        // between the setup edge and the access edge is kept for the next read.
        if (access && !pwrite && paddr == `ACL_APB_INT_STAT)
            d.int_stat = q.int_stat & ~q.prdata[2:0];
        // Events are set after the clear so that none is lost.
        if (q.req && link.ack)
        begin
            d.req = 1'b0;
            if (!q.wr)
                d.rdata = link.rdata;
            d.int_stat[`ACL_INT_DONE_BIT] = 1'b1;
        end
        // Falling line shows a clip, warning or tweeter detection.
        if (q.clip_prev && !link.clip_level)
            d.int_stat[`ACL_INT_CLIP_BIT] = 1'b1;
    end

    // Registers the whole controller state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q           <= '0;
            q.clip_prev <= 1'b1;
        end
        else
            q <= d;
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata     = q.prdata;
    assign pready     = access;
    assign pslverr    = 1'b0;
    assign irq        = |(q.int_stat & q.int_mask);
    assign link.req   = q.req;
    assign link.wr    = q.wr;
    assign link.addr  = q.addr;
    assign link.wdata = q.wdata;
endmodule : acl_host

// File: core/acl_link_if.sv
// Serial register link and clip/warning line between controller and amplifier.
`timescale 1ns/1ps
interface acl_link_if;
    logic       req;        // Request held by the controller until ack.
    logic       wr;         // High for a register write.
    logic [7:0] addr;       // Register offset.
    logic [7:0] wdata;      // Write data.
    logic       ack;        // One-cycle answer from the device.
    logic [7:0] rdata;      // Read data, valid with ack.
    logic       diag_busy;  // Device runs a load diagnostic.
    logic       clip_out;   // Open-drain level driven by the device.
    logic       clip_oe;    // High while the device pulls the line.
    logic       clip_level; // Resolved line level, pulled up when released.

    // The line floats high through its pull-up when nobody drives it.
    assign clip_level = clip_oe ? clip_out : 1'b1;

    modport dev  (input req, wr, addr, wdata, output ack, rdata, diag_busy, clip_out, clip_oe);
    modport host (output req, wr, addr, wdata, input ack, rdata, diag_busy, clip_level);
endinterface : acl_link_if

// File: core/acl_pkg.sv
// Types shared by the amplifier device end and its controller end.
package acl_pkg;
    // Per-channel state held in the mode register, two bits per channel.
    typedef enum logic [1:0] {
        ACL_HIZ  = 2'b00,
        ACL_MUTE = 2'b01,
        ACL_PLAY = 2'b10
    } acl_chmode_type;
    // Preamplifier gain codes, two bits per channel.
    typedef enum logic [1:0] {
        ACL_GAIN_12DB = 2'b00,
        ACL_GAIN_20DB = 2'b01,
        ACL_GAIN_26DB = 2'b10,
        ACL_GAIN_32DB = 2'b11
    } acl_gain_type;
    // Source reported on the clip/warning output.
    typedef enum logic [1:0] {
        ACL_SRC_CLIP  = 2'b00,
        ACL_SRC_WARN  = 2'b01,
        ACL_SRC_BOTH  = 2'b10,
        ACL_SRC_TWEET = 2'b11
    } acl_clip_src_type;
    // Load diagnostic sequencer states.
    typedef enum logic [0:0] {
        ACL_DIAG_IDLE = 1'b0,
        ACL_DIAG_RUN  = 1'b1
    } acl_diag_state_type;
endpackage : acl_pkg

// File: core/acl_ramp.sv
// Gradual gain ramp of one amplifier channel.
`timescale 1ns/1ps
module acl_ramp
    import acl_pkg::*;
#(
    parameter int LEVEL_W  = 6,
    parameter int STEP_CYC = 250
)(
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               target_up,
    input  wire logic               force_zero,
    output logic [LEVEL_W-1:0]      level,
    output logic                    at_zero
);
    initial
    begin
        if (LEVEL_W < 1 || STEP_CYC < 1)
            $error("acl_ramp: bad LEVEL_W or STEP_CYC");
    end

    localparam int CNT_W = $clog2(STEP_CYC + 1);
    localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);

    typedef struct packed {
        logic [LEVEL_W-1:0] level; // Present gain level, zero is silent.
        logic [CNT_W-1:0]   cnt;   // Cycles spent at the present step.
    } acl_ramp_state_type;

    acl_ramp_state_type q, d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // One step every STEP_CYC cycles toward the target; a fault jumps to zero.
    always_comb
    begin
        d = q;
        if (force_zero)
        begin
            d.level = '0;
            d.cnt   = '0;
        end
        else if ((target_up && !(&q.level)) || (!target_up && (|q.level)))
        begin
            if (q.cnt == STEP_LAST)
            begin
                d.cnt = '0;
                // A step of one level keeps the change inaudible.
                d.level = target_up ? q.level + 1'b1 : q.level - 1'b1;
            end
            else
                d.cnt = q.cnt + 1'b1;
        end
        else
            d.cnt = '0;
    end

    // Registers the ramp state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign level   = q.level;
    assign at_zero = (q.level == '0);
endmodule : acl_ramp

// File: core/acl_regs.svh
// Register offsets, field positions, reset values and timing counts of the amplifier control.
`ifndef ACL_REGS_SVH
`define ACL_REGS_SVH
// ****************************************************************
// Device registers, reached through the serial link
// ****************************************************************
`define ACL_REG_FAULT       8'h00
`define ACL_REG_GAIN        8'h06
`define ACL_REG_CTRL        8'h07
`define ACL_REG_DIAG_STAT   8'h08
`define ACL_REG_CLIP_SRC    8'h0a
`define ACL_REG_MODE        8'h0c
`define ACL_REG_DIAG_BASE   8'h10
`define ACL_REG_DIAG_LAST   8'h13
`define ACL_CTRL_OFFSET_BIT 0
`define ACL_CTRL_START_BIT  1
`define ACL_CTRL_TWEET_BIT  2
`define ACL_CTRL_RESET      8'h01
`define ACL_MODE_RESET      8'h00
`define ACL_GAIN_RESET      8'h00
`define ACL_CLIP_SRC_RESET  2'h1
// ****************************************************************
// Controller registers, reached over APB
// ****************************************************************
`define ACL_APB_CMD         12'h000
`define ACL_APB_STATUS      12'h004
`define ACL_APB_INT_STAT    12'h008
`define ACL_APB_INT_MASK    12'h00c
`define ACL_CMD_WRITE_BIT   16
`define ACL_INT_DONE_BIT    0
`define ACL_INT_CLIP_BIT    1
`define ACL_INT_REFUSE_BIT  2
// ****************************************************************
// Timing
// ****************************************************************
`define ACL_CLK_PERIOD_NS   8
`define ACL_RAMP_STEP_NS    2000
`define ACL_RAMP_STEP_CYC   ((`ACL_RAMP_STEP_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_PWM_PERIOD_NS   2000
`define ACL_PWM_PERIOD_CYC  ((`ACL_PWM_PERIOD_NS + `ACL_CLK_PERIOD_NS - 1) / `ACL_CLK_PERIOD_NS)
`define ACL_DIAG_PHASE_CYC  1024
`endif

// File: sim/acl_monitor.sv
// Checker of the link between the controller end and the amplifier end.
`timescale 1ns/1ps
module acl_monitor (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       req,
    input wire logic       ack,
    input wire logic [7:0] addr,
    input wire logic       clip_oe,
    input wire logic       clip_out,
    input wire logic       clip_level
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ack_pulse_a: assert property (ack |=> !ack [*2]) else $error("ack too long");
    ack_cause_a: assert property ($rose(ack) |-> $past(req)) else $error("ack with no req");
    req_answer_a: assert property ($rose(req) |=> ack) else $error("ack late");
    req_release_a: assert property (ack |=> !req) else $error("req kept");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr)) else $error("req moved");
    clip_drive_a: assert property (clip_oe |-> !clip_out) else $error("clip high");
    clip_float_a: assert property (!clip_oe |-> clip_level) else $error("clip float");
    clip_width_a: assert property ($fell(clip_level) |-> !clip_level [*4])
        else $error("clip pulse short");
endmodule : acl_monitor

// File: sim/amp_channel_state_and_load_diag_bench.sv
// Self-checking bench of the two amplifier link ends.
`timescale 1ns/1ps
module amp_channel_state_and_load_diag_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, irq, off_en;
    logic clip_detect = 0, temperature_warning = 0, over_threshold = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [4:0] fault_in = '0;
    logic [3:0] diag_sense = '0, ch_hiz;
    logic [3:0][5:0] lvl;
    logic [7:0] gain_sel, g;
    int n_mismatch = 0, checks = 0, cyc = 0;
    int m [int]; // Model of the device registers as written.
    acl_link_if link ();
    acl_host acl_host_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr(), .irq, .link);
    acl_device #(.STEP_CYC(2), .PWM_CYC(4), .PHASE_CYC(32)) acl_device_inst (.pclk,
        .presetn, .link, .fault_in, .clip_detect, .temperature_warning, .over_threshold,
        .diag_sense, .ch_hiz, .ch_gain_level(lvl), .gain_sel, .offset_reduction_en(off_en),
        .diag_active(), .diag_phase());
    acl_monitor acl_monitor_inst (.pclk, .presetn, .req(link.req), .ack(link.ack),
        .addr(link.addr), .clip_oe(link.clip_oe), .clip_out(link.clip_out),
        .clip_level(link.clip_level));
    always #4 pclk = ~pclk;
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'h1);
        r = prdata;
        {psel, penable} <= 2'h0;
    endtask : apb
    // One link transfer, then poll until idle; read data ends in r[15:8].
    task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        if (w) m[a] = d;
        apb(1, 12'h000, {15'h0, w, a, d});
        r = 1;
        while (r[0] === 1'h1) apb(0, 12'h004, 0);
    endtask : dev
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
        checks++;
        if (v !== e) begin $display("Error %s exp %h got %h", s, e, v); n_mismatch++; end
    endtask : chk
    task automatic test_done;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Cut a hang short.
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000) begin n_mismatch++; test_done(); end
    end
    initial
    begin
        void'($urandom(32'he210));
        repeat (6) @(posedge pclk);
        presetn <= 1;
        g = $urandom;
        dev(1, 8'h06, g);
        dev(0, 8'h06, 0);
        chk("gain", m[6], r[15:8]);
        chk("gain_sel", g, gain_sel);
        for (int i = 0; i < 4; i++)
        begin
            dev(1, 8'h0a, i);
            dev(0, 8'h0a, 0);
            chk("clip_src", m[10], r[15:8]);
        end
        dev(1, 8'h07, 0);
        chk("offset_en", 0, off_en);
        apb(1, 12'h00c, 32'h6);
        dev(1, 8'h0c, 8'haa);
        chk("ramping", 0, lvl[0] == 6'h3f);
        repeat (300) @(posedge pclk);
        chk("level", 63, lvl[0]);
        dev(1, 8'h07, 8'h02);
        dev(0, 8'h08, 0);
        chk("diag_play", 0, r[8]);
        dev(1, 8'h0c, 8'h55);
        dev(1, 8'h0c, 8'h00);
        dev(1, 8'h07, 8'h02);
        dev(0, 8'h08, 0);
        chk("diag_ramp", 0, r[8]);
        chk("hiz_wait", 4'h0, ch_hiz);
        g = 8'h1 << ($urandom % 5);
        fault_in <= g[4:0];
        repeat (2) @(posedge pclk);
        fault_in <= 0;
        m[12] = 0;
        chk("fault_lvl", 0, lvl);
        chk("fault_hiz", 4'hf, ch_hiz);
        dev(0, 8'h00, 0);
        chk("fault", g, r[15:8]);
        diag_sense <= $urandom;
        dev(1, 8'h07, 8'h02);
        dev(0, 8'h08, 0);
        chk("full", 2'h3, r[9:8]);
        apb(1, 12'h000, 32'h10c55);
        apb(0, 12'h008, 0);
        chk("refused", 1, r[2]);
        repeat (600) @(posedge pclk);
        dev(0, 8'h10, 0);
        chk("result", {4{diag_sense[0]}}, r[11:8]);
        dev(0, 8'h0c, 0);
        chk("mode", m[12], r[15:8]);
        dev(1, 8'h07, 8'h04);
        dev(1, 8'h0a, 8'h03);
        dev(1, 8'h0c, 8'h02);
        chk("tweet_play", 4'he, ch_hiz);
        apb(0, 12'h008, 0);
        over_threshold <= 1;
        @(posedge pclk);
        over_threshold <= 0;
        repeat (2) @(posedge pclk);
        chk("clip_line", 0, link.clip_level);
        repeat (2) @(posedge pclk);
        chk("irq", 1, irq);
        apb(0, 12'h008, 0);
        chk("clip_int", 1, r[1]);
        @(posedge pclk);
        chk("irq_clear", 0, irq);
        test_done();
    end
endmodule : amp_channel_state_and_load_diag_bench
